// file: mcp_consts.svh
`ifndef MCP_CONSTS_SVH
`define MCP_CONSTS_SVH
// Command word bit positions
`define MCP_CMD_SEQ_EN 0
`define MCP_CMD_START 1
`define MCP_CMD_ISTART 2
`define MCP_CMD_MRESET 4
`define MCP_CMD_TEACH 5
`define MCP_CMD_STOP 15
// Manual word bit positions
`define MCP_MAN_SERVO_LOCK 0
`define MCP_MAN_OVR_EN 5
`define MCP_MAN_ORG_SEARCH 10
`define MCP_MAN_ORG_RETURN 11
// Override divisor, percent
`define MCP_OVR_DIV 32'h00000064
// Mask of implemented command and acknowledge bits
`define MCP_CMD_MASK 16'h8037
// Speed ramp tick: 1 ms at 40 MHz
`define MCP_CLK_HZ 40000000
`define MCP_TICK_MS 1
`define MCP_TICK_CYC (`MCP_CLK_HZ / 1000 * `MCP_TICK_MS)
// Controller register byte offsets
`define MCP_OFS_MANUAL 5'h00
`define MCP_OFS_OVR 5'h04
`define MCP_OFS_CMD 5'h08
`define MCP_OFS_SEQ 5'h0C
`define MCP_OFS_TEACH 5'h10
`define MCP_OFS_ACK 5'h14
`define MCP_OFS_STAT 5'h18
// Reset values
`define MCP_RST_WORD 16'h0000
`define MCP_RST_OVR 16'h0064
`endif

// file: mcp_pkg.sv
package mcp_pkg;
	// End pattern of a sequence entry
	typedef enum logic [1:0] {
		MCP_END_INDIV,
		MCP_END_AUTO,
		MCP_END_CONT
	} mcp_end_t;
	// One sequence entry
	typedef struct packed {
		logic is_end;
		mcp_end_t pattern;
		logic [31:0] position;
		logic [15:0] speed;
		logic [15:0] acc_ms;
		logic [15:0] dec_ms;
		logic [15:0] m_code;
	} mcp_seq_t;
	// Device run states
	typedef enum logic [1:0] {
		MCP_ST_IDLE,
		MCP_ST_RUN,
		MCP_ST_STOP
	} mcp_state_t;
endpackage

// file: mcp_link_if.sv
`timescale 1ns/1ps
interface mcp_link_if;
	// Command area, written by the controller
	logic [15:0] manual_word;
	logic [15:0] override_word;
	logic [15:0] command_word;
	logic [15:0] start_seq_word;
	logic [15:0] teach_word;
	// Status area, written by the unit
	logic [15:0] ack_word;
	logic busy;
	logic error;
	logic [15:0] seq_number;
	logic [15:0] m_code;
	modport dev (
		input manual_word, override_word, command_word,
		input start_seq_word, teach_word,
		output ack_word, busy, error, seq_number, m_code
	);
	modport ctl (
		output manual_word, override_word, command_word,
		output start_seq_word, teach_word,
		input ack_word, busy, error, seq_number, m_code
	);
endinterface

// file: mcp_unit.sv
// How it works
// RULE1 - Phase time is speed delta over span times
// RULE2 - Keep current sequence times until next begins
// RULE3 - Faster next speed ramps with acceleration time
// RULE4 - Slower next speed ramps with deceleration time
// RULE5 - Sequence enable loads start number for start
// RULE6 - Start bit runs sequences by end pattern
// RULE7 - Individual start stops after each sequence
// RULE8 - M code reset bit clears M code
// RULE9 - Teach bit stores position at teach address
// RULE10 - Stop bit decelerates running operation to halt
// RULE11 - Controller writes start number as full word
// RULE12 - Controller writes teach target as full word
// RULE13 - Override scales speed by word over 100
// RULE14 - Manual origin or lock commands clear number
// RULE15 - Each command bit has an acknowledge flag
// RULE16 - Commands act once per off-to-on edge
`include "mcp_consts.svh"
`timescale 1ns/1ps
module mcp_unit #(
	parameter int SEQ_DEPTH = 16,
	parameter int TICK_CYC = `MCP_TICK_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Command and status area
	mcp_link_if.dev link,
	// Axis parameters
	input wire logic [15:0] max_speed,
	input wire logic [15:0] start_speed,
	// Sequence table load port
	input wire logic tbl_we,
	input wire logic [15:0] tbl_addr,
	input wire mcp_pkg::mcp_seq_t tbl_data,
	// Axis feedback
	input wire logic at_target,
	input wire logic [31:0] present_pos,
	input wire logic preset_cmd,
	// Profile outputs
	output logic [15:0] speed_cmd,
	output logic [31:0] target_pos,
	output logic [15:0] phase_time
);
	localparam int IW = $clog2(SEQ_DEPTH);
	// Table depth must be a power of two for wrap-around indexing
	if (SEQ_DEPTH < 2 || SEQ_DEPTH > 65536 ||
	    (SEQ_DEPTH & (SEQ_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("mcp_unit: SEQ_DEPTH unsupported");
	end
	// The tick divider needs at least one cycle per tick
	if (TICK_CYC < 1) begin : g_bad_tick
		$error("mcp_unit: TICK_CYC unsupported");
	end

	// Scaled speed, clipped to 16 bits
	function automatic logic [15:0] eff_speed(input logic [15:0] s,
		input logic [15:0] ovr, input logic en);
		logic [31:0] p;
		p = 32'(s) * 32'(ovr) / `MCP_OVR_DIV;
		if (!en)
			eff_speed = s;
		else if (p > 32'h0000FFFF)
			eff_speed = 16'hFFFF;
		else
			eff_speed = p[15:0];
	endfunction
	// Phase time = delta / (vmax - v0) * t
	function automatic logic [15:0] phase_ms(input logic [15:0] dv,
		input logic [15:0] t, input logic [15:0] span);
		logic [31:0] q;
		q = (span == 16'h0000) ? 32'h0 : 32'(dv) * 32'(t) / 32'(span);
		phase_ms = (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
	endfunction
	// Speed change per tick; zero time means a step change
	function automatic logic [15:0] step_of(input logic [15:0] span,
		input logic [15:0] t);
		logic [15:0] s;
		s = (t == 16'h0000) ? 16'hFFFF : span / t;
		step_of = (s == 16'h0000) ? 16'h0001 : s;
	endfunction

	mcp_pkg::mcp_seq_t table_mem [SEQ_DEPTH];
	mcp_pkg::mcp_state_t state;
	logic [15:0] cmd_prev; // Last command word seen
	logic [15:0] man_prev; // Last manual word seen
	logic preset_prev;
	logic [IW-1:0] seq; // Sequence now or next to run
	logic [IW-1:0] base_seq; // Number last enabled
	logic seq_valid;
	logic indiv_mode;
	logic auto_pending; // Restart after this stop
	logic switch_pending; // Own times wait for speed
	logic [15:0] ramp_acc;
	logic [15:0] ramp_dec;
	logic [15:0] target_speed;
	logic [15:0] ack_word;
	logic [15:0] m_code;
	logic error;
	logic run_flag; // Registered busy, so the status pin has no decode
	logic [$clog2(TICK_CYC+1)-1:0] tick_cnt;

	// Off-to-on edges of command bits
	wire [15:0] cmd_rise = link.command_word & ~cmd_prev; // see RULE16
	wire [15:0] man_rise = link.manual_word & ~man_prev;
	wire clr_seq = man_rise[`MCP_MAN_SERVO_LOCK] |
		man_rise[`MCP_MAN_ORG_SEARCH] | man_rise[`MCP_MAN_ORG_RETURN] |
		(preset_cmd & ~preset_prev); // see RULE14
	wire ovr_en = link.manual_word[`MCP_MAN_OVR_EN];
	wire tick = (tick_cnt == '0);
	wire [15:0] span = max_speed - start_speed;
	wire mcp_pkg::mcp_seq_t cur = table_mem[seq];
	wire mcp_pkg::mcp_seq_t nxt = table_mem[seq + IW'(1)];
	wire [15:0] cur_speed = eff_speed(cur.speed, link.override_word,
		ovr_en); // see RULE13
	wire [15:0] nxt_speed = eff_speed(nxt.speed, link.override_word,
		ovr_en); // see RULE13
	wire do_start = cmd_rise[`MCP_CMD_START] | cmd_rise[`MCP_CMD_ISTART];
	wire [IW-1:0] req_seq = link.start_seq_word[IW-1:0];
	// Distance left to the current target speed
	wire up = target_speed > speed_cmd;
	wire [15:0] gap = up ? target_speed - speed_cmd :
		speed_cmd - target_speed;
	wire [15:0] step = step_of(span, up ? ramp_acc : ramp_dec);
	wire [15:0] ramped = (gap <= step) ? target_speed :
		(up ? speed_cmd + step : speed_cmd - step);
	// Stop is complete once speed falls to the starting speed
	wire stopped = (speed_cmd <= start_speed);

	assign link.ack_word = ack_word;
	assign link.busy = run_flag;
	assign link.error = error;
	assign link.seq_number = 16'(seq);
	assign link.m_code = m_code;

	// Ramp tick divider
	always_ff @(posedge core_clk) begin
		if (!rst_b || tick)
			tick_cnt <= ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
		else
			tick_cnt <= tick_cnt - 1'b1;
	end

	// Sequence table; teaching wins over a load in the same cycle
	always_ff @(posedge core_clk) begin
		if (cmd_rise[`MCP_CMD_TEACH] && rst_b)
			table_mem[link.teach_word[IW-1:0]].position <=
				present_pos; // see RULE9
		else if (tbl_we)
			table_mem[tbl_addr[IW-1:0]] <= tbl_data;
	end

	// Command edges and acknowledges
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			cmd_prev <= `MCP_RST_WORD;
			man_prev <= `MCP_RST_WORD;
			preset_prev <= 1'b0;
			ack_word <= `MCP_RST_WORD;
		end else begin
			cmd_prev <= link.command_word;
			man_prev <= link.manual_word;
			preset_prev <= preset_cmd;
			ack_word <= link.command_word & `MCP_CMD_MASK; // see RULE15
		end
	end

	// Sequencer and speed profile
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= mcp_pkg::MCP_ST_IDLE;
			run_flag <= 1'b0;
			seq <= '0;
			base_seq <= '0;
			seq_valid <= 1'b0;
			indiv_mode <= 1'b0;
			auto_pending <= 1'b0;
			switch_pending <= 1'b0;
			ramp_acc <= 16'h0000;
			ramp_dec <= 16'h0000;
			target_speed <= 16'h0000;
			speed_cmd <= 16'h0000;
			target_pos <= 32'h00000000;
			phase_time <= 16'h0000;
			m_code <= 16'h0000;
			error <= 1'b0;
		end else begin
			// Reset wins over an M code output in the same cycle
			if (cmd_rise[`MCP_CMD_MRESET])
				m_code <= 16'h0000; // see RULE8
			else if (state == mcp_pkg::MCP_ST_RUN && at_target)
				m_code <= cur.m_code;
			// Clearing forgets the number as well as its validity
			if (clr_seq) begin
				seq <= '0; // see RULE14
				seq_valid <= 1'b0;
			end else if (cmd_rise[`MCP_CMD_SEQ_EN]) begin
				seq <= req_seq; // see RULE5
				base_seq <= req_seq;
				seq_valid <= 1'b1;
			end
			case (state)
			mcp_pkg::MCP_ST_IDLE: begin
				speed_cmd <= 16'h0000;
				if ((do_start || auto_pending) && !clr_seq) begin
					auto_pending <= 1'b0;
					if (!seq_valid && !auto_pending)
						error <= 1'b1;
					else if (cur.is_end) begin
						seq <= base_seq; // END returns to enabled number
					end else begin
						error <= 1'b0;
						if (do_start)
							indiv_mode <= cmd_rise[`MCP_CMD_ISTART]; // see RULE7
						state <= mcp_pkg::MCP_ST_RUN; // see RULE6
						run_flag <= 1'b1;
						speed_cmd <= start_speed;
						target_speed <= cur_speed;
						target_pos <= cur.position;
						ramp_acc <= cur.acc_ms;
						ramp_dec <= cur.dec_ms;
						switch_pending <= 1'b0;
						phase_time <= phase_ms(cur_speed - start_speed,
							cur.acc_ms, span); // see RULE1
					end
				end
			end
			mcp_pkg::MCP_ST_RUN: begin
				if (tick)
					speed_cmd <= ramped; // see RULE3 RULE4
				// New sequence's own times once its speed is reached
				if (switch_pending && gap == 16'h0000) begin
					ramp_acc <= cur.acc_ms; // see RULE2
					ramp_dec <= cur.dec_ms;
					switch_pending <= 1'b0;
				end
				if (cmd_rise[`MCP_CMD_STOP]) begin
					state <= mcp_pkg::MCP_ST_STOP; // see RULE10
					target_speed <= start_speed;
					auto_pending <= 1'b0;
					phase_time <= phase_ms(speed_cmd - start_speed,
						ramp_dec, span); // see RULE1
				end else if (at_target) begin
					if (cur.pattern == mcp_pkg::MCP_END_CONT && !indiv_mode &&
					    !nxt.is_end) begin
						// Ramp with the outgoing sequence's times
						seq <= seq + IW'(1);
						target_speed <= nxt_speed;
						target_pos <= nxt.position;
						switch_pending <= 1'b1; // see RULE2
						if (nxt_speed > speed_cmd)
							phase_time <= phase_ms(nxt_speed - speed_cmd,
								ramp_acc, span); // see RULE3 RULE1
						else
							phase_time <= phase_ms(speed_cmd - nxt_speed,
								ramp_dec, span); // see RULE4 RULE1
					end else begin
						seq <= seq + IW'(1);
						state <= mcp_pkg::MCP_ST_STOP;
						target_speed <= start_speed;
						auto_pending <= cur.pattern != mcp_pkg::MCP_END_INDIV &&
							!indiv_mode; // see RULE7
						phase_time <= phase_ms(speed_cmd - start_speed,
							ramp_dec, span); // see RULE1 RULE4
					end
				end
			end
			mcp_pkg::MCP_ST_STOP: begin
				if (tick)
					speed_cmd <= ramped; // see RULE4
				if (stopped) begin
					speed_cmd <= 16'h0000;
					state <= mcp_pkg::MCP_ST_IDLE;
					run_flag <= 1'b0;
				end
			end
			default: begin
				state <= mcp_pkg::MCP_ST_IDLE;
				run_flag <= 1'b0;
			end
			endcase
		end
	end
endmodule

// file: mcp_ctrl.sv
`include "mcp_consts.svh"
`timescale 1ns/1ps
module mcp_ctrl (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Command and status area
	mcp_link_if.ctl link
);
	logic [15:0] manual_word; // Manual command bits
	logic [15:0] override_word; // Override percent
	logic [15:0] command_word; // Memory command bits
	logic [15:0] start_seq_word; // Starting sequence number
	logic [15:0] teach_word; // Teaching target entry

	// Words go out whole, all 16 bits at once
	assign link.manual_word = manual_word;
	assign link.override_word = override_word;
	assign link.command_word = command_word; // see RULE5 RULE6
	assign link.start_seq_word = start_seq_word; // see RULE11
	assign link.teach_word = teach_word; // see RULE12

	// Register read selection; unmapped reads return zero
	wire [31:0] stat_word = {link.m_code, 6'h00, link.error, link.busy,
		link.seq_number[7:0]};
	wire [31:0] rd_sel =
		(avs_address == `MCP_OFS_MANUAL) ? {16'h0000, manual_word} :
		(avs_address == `MCP_OFS_OVR) ? {16'h0000, override_word} :
		(avs_address == `MCP_OFS_CMD) ? {16'h0000, command_word} :
		(avs_address == `MCP_OFS_SEQ) ? {16'h0000, start_seq_word} :
		(avs_address == `MCP_OFS_TEACH) ? {16'h0000, teach_word} :
		(avs_address == `MCP_OFS_ACK) ? {16'h0000, link.ack_word} :
		(avs_address == `MCP_OFS_STAT) ? stat_word : 32'h00000000;
	// Access completes on the second edge of a request
	wire take = (avs_read | avs_write) & ~avs_waitrequest;

	// Bus handshake: one wait cycle gives readdata a flop stage
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= rd_sel;
		end
	end

	// Command register writes
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			manual_word <= `MCP_RST_WORD;
			override_word <= `MCP_RST_OVR;
			command_word <= `MCP_RST_WORD;
			start_seq_word <= `MCP_RST_WORD;
			teach_word <= `MCP_RST_WORD;
		end else if (take && avs_write) begin
			case (avs_address)
			`MCP_OFS_MANUAL: manual_word <= avs_writedata[15:0];
			`MCP_OFS_OVR: override_word <= avs_writedata[15:0];
			`MCP_OFS_CMD: command_word <= avs_writedata[15:0];
			`MCP_OFS_SEQ: start_seq_word <= avs_writedata[15:0];
			`MCP_OFS_TEACH: teach_word <= avs_writedata[15:0];
			default: ;
			endcase
		end
	end
endmodule

// file: mcp_link_chk.sv
`timescale 1ns/1ps
module mcp_link_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Command area
	input wire logic [15:0] manual_word,
	input wire logic [15:0] override_word,
	input wire logic [15:0] command_word,
	input wire logic [15:0] start_seq_word,
	input wire logic [15:0] teach_word,
	// Status area
	input wire logic [15:0] ack_word,
	input wire logic busy,
	input wire logic error,
	input wire logic [15:0] seq_number,
	input wire logic [15:0] m_code
);
	// One clock domain, so one default for all
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Flags mirror implemented bits, one cycle on
	ack_follow_a: assert property (
		ack_word == ($past(command_word) & 16'h8037))
		else $error("ack word differs from command");
	start_run_a: assert property (
		$rose(command_word[1]) && !busy |=> busy || error)
		else $error("start did not run");
	istart_run_a: assert property (
		$rose(command_word[2]) && !busy |=> busy || error)
		else $error("individual start did not run");
	// Two idle cycles rule out the automatic restart
	start_edge_a: assert property (
		!busy && !$past(busy) && command_word[1] &&
		$stable(command_word) |=> !busy)
		else $error("held start bit restarted");
	mreset_clear_a: assert property (
		$rose(command_word[4]) |=> m_code == 16'h0000)
		else $error("M code not cleared");
	seq_clear_a: assert property (
		$rose(manual_word[0]) || $rose(manual_word[10]) ||
		$rose(manual_word[11]) |=> seq_number == 16'h0000)
		else $error("sequence number not cleared");
	// Bounded because the ramp length is set by the bench
	stop_halt_a: assert property (
		$rose(command_word[15]) && busy |-> ##[1:1000] !busy)
		else $error("stop did not halt");
	error_idle_a: assert property (
		$rose(error) |-> !busy)
		else $error("error raised while running");
endmodule

// file: memory_operation_command_profile_tb.sv
`timescale 1ns/1ps
module memory_operation_command_profile_tb;
	// Clock, reset and bus master
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	// Axis, table and feedback inputs
	logic [15:0] max_speed = 16'h03E8;
	logic [15:0] start_speed = 16'h0064;
	logic tbl_we = 1'b0;
	logic [15:0] tbl_addr = 16'h0000;
	mcp_pkg::mcp_seq_t tbl_data = '0;
	logic at_target = 1'b0;
	logic [31:0] present_pos = 32'h00000000;
	logic preset_cmd = 1'b0;
	logic [15:0] speed_cmd;
	logic [15:0] phase_time;
	logic [31:0] target_pos;
	// Expected notes: select, mask, value
	logic [64:0] exp_q[$];
	logic [64:0] x;
	logic [31:0] got;
	logic probe = 1'b0;
	logic probe_sel = 1'b0;
	logic [31:0] lfsr = 32'hD894D696;
	logic [31:0] pos;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	always #12.5 core_clk = ~core_clk;
	mcp_link_if link_i();
	mcp_ctrl i_mcp_ctrl (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link_i));
	// Short tick keeps each ramp to a few dozen cycles
	mcp_unit #(.SEQ_DEPTH(16), .TICK_CYC(4)) i_mcp_unit (
		.core_clk(core_clk), .rst_b(rst_b), .link(link_i),
		.max_speed(max_speed), .start_speed(start_speed),
		.tbl_we(tbl_we), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
		.at_target(at_target), .present_pos(present_pos),
		.preset_cmd(preset_cmd), .speed_cmd(speed_cmd),
		.target_pos(target_pos), .phase_time(phase_time));
	mcp_link_chk i_mcp_link_chk (.core_clk(core_clk), .rst_b(rst_b),
		.manual_word(link_i.manual_word),
		.override_word(link_i.override_word),
		.command_word(link_i.command_word),
		.start_seq_word(link_i.start_seq_word),
		.teach_word(link_i.teach_word), .ack_word(link_i.ack_word),
		.busy(link_i.busy), .error(link_i.error),
		.seq_number(link_i.seq_number), .m_code(link_i.m_code));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Verdict and end of run
	task automatic print_verdict();
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One Avalon access; an idle edge follows before the next
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge core_clk);
		// Waits as long as the slave asks; only the ceiling ends a hang
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d});
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		exp_q.push_back({1'b0, m, e});
		bus(1'b0, a, 32'h00000000);
	endtask
	// Probe: 0 looks at phase and speed, 1 at target position
	task automatic look(input logic s, input logic [31:0] e);
		exp_q.push_back({s, 32'hFFFFFFFF, e});
		probe <= 1'b1;
		probe_sel <= s;
		@(posedge core_clk);
		probe <= 1'b0;
		@(posedge core_clk);
	endtask
	// Wait for the ramp to land, then look at it
	task automatic settle(input logic [15:0] v, input logic [15:0] t);
		int n;
		n = 0;
		while (speed_cmd !== v && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		look(1'b0, {t, v});
	endtask
	task automatic arrive();
		at_target <= 1'b1;
		@(posedge core_clk);
		at_target <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic load(input logic [15:0] a, input mcp_pkg::mcp_end_t p,
		input logic [15:0] v, input logic [15:0] ac,
		input logic [15:0] dc, input logic [15:0] mc);
		tbl_we <= 1'b1;
		tbl_addr <= a;
		tbl_data <= '{is_end: 1'b0, pattern: p,
			position: {16'h0000, a}, speed: v, acc_ms: ac,
			dec_ms: dc, m_code: mc};
		@(posedge core_clk);
		tbl_we <= 1'b0;
		@(posedge core_clk);
	endtask
	// Oldest note is compared whenever a result shows
	always @(posedge core_clk) begin
		cycles++;
		if ((avs_read && !avs_waitrequest) || probe) begin
			got = !probe ? avs_readdata :
				probe_sel ? target_pos : {phase_time, speed_cmd};
			x = exp_q.pop_front();
			compares++;
			if (((got ^ x[31:0]) & x[63:32]) !== 32'h00000000) begin
				n_mismatch++;
				$display("mismatch %0t: got %h want %h", $time, got, x[31:0]);
			end
		end
		if (cycles == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(5'h04, 32'hFFFFFFFF, 32'h00000064);
		rd(5'h08, 32'hFFFFFFFF, 32'h00000000);
		rd(5'h1C, 32'hFFFFFFFF, 32'h00000000);
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 32'hFFFFFFFF, 32'h00000000);
		load(16'h0000, mcp_pkg::MCP_END_CONT, 16'h0226, 16'h0012,
			16'h0009, 16'h0011);
		load(16'h0001, mcp_pkg::MCP_END_CONT, 16'h0352, 16'h0024,
			16'h001E, 16'h0022);
		load(16'h0002, mcp_pkg::MCP_END_INDIV, 16'h0190, 16'h0009,
			16'h000C, 16'h0033);
		// Start with no number enabled is refused
		wr(5'h08, 16'h0002);
		rd(5'h18, 32'h00000300, 32'h00000200);
		rd(5'h14, 32'hFFFFFFFF, 32'h00000002);
		wr(5'h08, 16'h0000);
		// Chain of three: up, up again, then down
		wr(5'h0C, 16'h0000);
		wr(5'h08, 16'h0001);
		wr(5'h08, 16'h0003);
		settle(16'h0226, 16'h0009);
		rd(5'h18, 32'h000001FF, 32'h00000100);
		arrive();
		settle(16'h0352, 16'h0006);
		arrive();
		settle(16'h0190, 16'h000F);
		arrive();
		repeat (100) @(posedge core_clk);
		rd(5'h18, 32'hFFFF01FF, 32'h00330003);
		wr(5'h08, 16'h0010);
		rd(5'h18, 32'hFFFF0000, 32'h00000000);
		// Individual start at double override
		wr(5'h00, 16'h0020);
		wr(5'h04, 16'h00C8);
		wr(5'h0C, 16'h0000);
		wr(5'h08, 16'h0001);
		wr(5'h08, 16'h0005);
		settle(16'h044C, 16'h0014);
		arrive();
		repeat (100) @(posedge core_clk);
		rd(5'h18, 32'hFFFF01FF, 32'h00110001);
		// Stop in mid-ramp keeps the number
		wr(5'h08, 16'h0000);
		wr(5'h08, 16'h0004);
		wr(5'h08, 16'h8004);
		repeat (300) @(posedge core_clk);
		rd(5'h18, 32'h000001FF, 32'h00000001);
		wr(5'h00, 16'h0021);
		rd(5'h18, 32'h000000FF, 32'h00000000);
		// Teach a random position into entry two
		lfsr = next_rand(lfsr);
		pos = lfsr;
		present_pos <= pos;
		wr(5'h10, 16'h0002);
		wr(5'h08, 16'h0020);
		present_pos <= next_rand(lfsr);
		wr(5'h0C, 16'h0002);
		wr(5'h08, 16'h0001);
		wr(5'h08, 16'h0003);
		repeat (4) @(posedge core_clk);
		look(1'b1, pos);
		print_verdict();
	end
endmodule
